// file: space_pkg.sv
package space_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CDB0 = 8'h00;
  localparam logic [7:0] REG_CDB1 = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_INFO = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control and status bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_DIRSUP = 1;
  localparam int CTRL_NATIVE = 2;
  localparam int CTRL_AFTER_WR = 3;
  localparam int CTRL_DISC = 4;
  localparam int SB_DONE = 1;
  localparam int CDB_DETECT_BIT = 15;
  // ==========================================================
  // command encodings
  localparam logic [7:0] OPC_SPACE = 8'h11;
  localparam logic [2:0] CODE_BLOCKS = 3'h0;
  localparam logic [2:0] CODE_FMARKS = 3'h1;
  localparam logic [2:0] CODE_TO_END = 3'h3;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_MEDIUM = 4'h3;
  localparam logic [3:0] SK_HW = 4'h4;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_BLANK = 4'h8;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int FLUSH_MAX_S = 12;
  localparam int FLUSH_CYCLES = FLUSH_MAX_S * CLK_HZ;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_FLUSH = 2'b10,
    ST_MOVE = 2'b11
  } eng_state_e;
  // ==========================================================
  // helpers
  function automatic logic [23:0] neg24(input logic [23:0] v);
    neg24 = 24'(~v + 24'h000001);
  endfunction
  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge32[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// file: item_counter.sv
`timescale 1ns/10ps
// items still to pass; the last flag fires on the item that empties it
module item_counter (
  input logic aclk,
  input logic aresetn,
  input logic load,
  input logic [23:0] load_value,
  input logic dec,
  output logic [23:0] remaining,
  output logic last
);
  logic [23:0] remaining_q;
  assign remaining = remaining_q;
  assign last = dec && (remaining_q == 24'h000001);
  // ==========================================================
  // down counter, saturating at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remaining_q <= 24'h000000;
    end else if (load) begin
      remaining_q <= load_value;
    end else if (dec && remaining_q != 24'h000000) begin
      remaining_q <= 24'(remaining_q - 24'h000001);
    end
  end
endmodule

// file: axil_port.sv
`timescale 1ns/10ps
// axi4-lite slave shell; address and data may arrive in either order
module axil_port (
  input logic aclk,
  input logic aresetn,
  input logic [space_pkg::ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [space_pkg::ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  output logic wr_en,
  output logic [space_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input logic wr_ok,
  output logic [space_pkg::ADDR_W-1:0] rd_addr,
  input logic [31:0] rd_data,
  input logic rd_ok
);
  import space_pkg::*;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // ==========================================================
  // handshake decode
  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign wr_en = aw_have_q && w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign rd_addr = araddr;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  // write side: hold both halves, commit once, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  // read side: data captured with the address, one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok ? rd_data : 32'h00000000;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// file: space_engine.sv
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
// space command engine: software loads the command block, the engine
// drives a positioning service and reports status and sense
module space_engine #(
  parameter int FLUSH_LIMIT = space_pkg::FLUSH_CYCLES
) (
  input logic aclk,
  input logic aresetn,
  input logic [space_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [space_pkg::ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic flush_req,
  input logic flush_done,
  input logic flush_fail,
  output logic move_req,
  output logic move_reverse,
  output logic [2:0] move_kind,
  output logic move_fast,
  output logic park_at_start,
  output logic bus_release,
  input logic item_pulse,
  input logic item_is_fm,
  input logic item_fixed,
  input logic end_of_data_mark,
  input logic physical_tape_end,
  input logic physical_tape_start,
  input logic media_fault,
  input logic hw_fault,
  input logic [23:0] unreadable_blocks
);
  import space_pkg::*;
  eng_state_e state_q, state_d;
  logic [31:0] cdb0_q;
  logic [15:0] cdb1_q;
  logic dirsup_q, native_q, after_wr_q, disc_q;
  logic done_q, check_q, valid_q, fm_q, fixed_q;
  logic end_of_medium_flag_q, physical_tape_end_q, logical_tape_start_q;
  logic [3:0] key_q;
  logic [23:0] info_q;
  logic [2:0] code_q;
  logic rev_q, always_detect_end_flag_q, fm_passed_q, mark_skipped_q, fast_q, park_q;
  logic [26:0] flush_cnt_q;
  logic wr_en, wr_ok, rd_ok;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [23:0] remaining;
  logic cnt_last;

  // ==========================================================
  // bus slave
  axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // address decode; unmapped offsets answer with slverr
  wire wr_cdb0 = wr_en && wr_addr == REG_CDB0;
  wire wr_cdb1 = wr_en && wr_addr == REG_CDB1;
  wire wr_ctrl = wr_en && wr_addr == REG_CTRL && wr_strb[0];
  wire wr_stat = wr_en && wr_addr == REG_STAT && wr_strb[0];
  wire busy = state_q != ST_IDLE;
  assign wr_ok = wr_addr inside {REG_CDB0, REG_CDB1, REG_CTRL, REG_STAT, REG_INFO};
  assign rd_ok = rd_addr inside {REG_CDB0, REG_CDB1, REG_CTRL, REG_STAT, REG_INFO};
  wire [31:0] stat_word = {18'h00000, fixed_q, logical_tape_start_q, physical_tape_end_q,
                           end_of_medium_flag_q, fm_q, valid_q, key_q,
                           1'b0, check_q, done_q, busy};
  wire [31:0] ctrl_word = {27'h0000000, disc_q, after_wr_q, native_q, dirsup_q, 1'b0};
  assign rd_data = rd_addr == REG_CDB0 ? cdb0_q :
                   rd_addr == REG_CDB1 ? {16'h0000, cdb1_q} :
                   rd_addr == REG_CTRL ? ctrl_word :
                   rd_addr == REG_STAT ? stat_word :
                   rd_addr == REG_INFO ? {{8{info_q[23]}}, info_q} : 32'h00000000;

  // ==========================================================
  // command block fields
  wire [7:0] opc_w = cdb0_q[7:0];
  wire [2:0] code_w = cdb0_q[10:8];
  wire [23:0] count_w = {cdb0_q[23:16], cdb0_q[31:24], cdb1_q[7:0]};
  wire count_neg = count_w[23];
  wire count_zero = count_w == 24'h000000;
  wire [23:0] magnitude = count_neg ? neg24(count_w) : count_w;
  wire start = wr_ctrl && wr_data[CTRL_START] && !busy;
  // forward covers end-of-data search too
  wire fwd_w = code_q == CODE_TO_END || !rev_q && !count_zero;
  wire code_ok = code_q inside {CODE_BLOCKS, CODE_FMARKS, CODE_TO_END};
  wire illegal = opc_w != OPC_SPACE || !code_ok ||
                 (code_q == CODE_TO_END && !native_q) || (after_wr_q && fwd_w);
  wire zero_noop = code_q != CODE_TO_END && count_zero;
  wire need_flush = rev_q && after_wr_q;
  wire flush_timeout = flush_cnt_q == 27'(FLUSH_LIMIT - 1);
  // early mark skipped only with directory firmware and flag clear
  wire mark_skip = dirsup_q && !always_detect_end_flag_q &&
                   !fm_passed_q && !mark_skipped_q;
  // filemarks count for op 001, blocks for op 000, whatever block size
  wire item_cnt = item_pulse && (code_q == CODE_FMARKS ? item_is_fm : !item_is_fm);
  wire fm_stop = item_pulse && item_is_fm && code_q == CODE_BLOCKS;
  wire [23:0] residue = rev_q ? neg24(remaining) : remaining;

  item_counter u_count (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(start),
    .load_value(magnitude),
    .dec(item_cnt && state_q == ST_MOVE),
    .remaining(remaining),
    .last(cnt_last)
  );

  // ==========================================================
  // ending of a command and its sense
  logic fin, f_check, f_valid, f_fm, f_medium_end, f_tape_end, f_tape_start, f_park;
  logic [3:0] f_key;
  logic [23:0] f_info;
  always_comb begin
    fin = 1'b0;
    f_check = 1'b1;
    f_key = SK_NONE;
    f_valid = 1'b0;
    f_fm = 1'b0;
    f_medium_end = 1'b0;
    f_tape_end = 1'b0;
    f_tape_start = 1'b0;
    f_park = 1'b0;
    f_info = 24'h000000;
    case (state_q)
      ST_DECODE: begin
        if (illegal) begin
          fin = 1'b1;
          f_key = SK_ILLEGAL;
        end else if (zero_noop) begin
          fin = 1'b1;
          f_check = 1'b0;
        end
      end
      ST_FLUSH: begin
        if (flush_fail || flush_timeout) begin
          fin = 1'b1;
          f_key = SK_MEDIUM;
        end
      end
      ST_MOVE: begin
        if (hw_fault || media_fault) begin
          // bad block is not counted, so residue still includes it
          fin = 1'b1;
          f_key = hw_fault ? SK_HW : SK_MEDIUM;
          f_valid = 1'b1;
          f_info = residue;
          if (!hw_fault && rev_q && unreadable_blocks != 24'h000000) begin
            f_info = neg24(unreadable_blocks);
          end
        end else if (physical_tape_end) begin
          fin = 1'b1;
          f_key = SK_MEDIUM;
          f_medium_end = 1'b1;
          f_tape_end = 1'b1;
          f_valid = 1'b1;
          f_info = code_q == CODE_TO_END ? 24'h000000 : residue;
        end else if (physical_tape_start) begin
          fin = 1'b1;
          f_medium_end = 1'b1;
          f_tape_start = 1'b1;
          f_valid = 1'b1;
          f_park = 1'b1;
          f_info = residue;
        end else if (end_of_data_mark && !mark_skip) begin
          fin = 1'b1;
          if (code_q != CODE_TO_END) begin
            f_key = SK_BLANK;
            f_valid = 1'b1;
            f_info = residue;
          end else begin
            f_check = 1'b0;
          end
        end else if (fm_stop) begin
          fin = 1'b1;
          f_fm = 1'b1;
          f_valid = 1'b1;
          f_info = residue;
        end else if (cnt_last && code_q != CODE_TO_END) begin
          fin = 1'b1;
          f_check = 1'b0;
        end
      end
      default: fin = 1'b0;
    endcase
  end

  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) state_d = ST_DECODE;
      ST_DECODE: state_d = fin ? ST_IDLE : need_flush ? ST_FLUSH : ST_MOVE;
      ST_FLUSH: state_d = fin ? ST_IDLE : flush_done ? ST_MOVE : ST_FLUSH;
      ST_MOVE: if (fin) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // outputs toward the transport
  assign flush_req = state_q == ST_FLUSH;
  assign move_req = state_q == ST_MOVE;
  assign move_reverse = rev_q;
  assign move_kind = code_q;
  assign move_fast = fast_q;
  assign park_at_start = park_q;
  // bus may be let go only while the tape is busy
  assign bus_release = disc_q && (state_q == ST_MOVE || state_q == ST_FLUSH);

  // state and per-command latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      code_q <= CODE_BLOCKS;
      rev_q <= 1'b0;
      always_detect_end_flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        code_q <= code_w;
        rev_q <= count_neg && code_w != CODE_TO_END;
        always_detect_end_flag_q <= cdb1_q[CDB_DETECT_BIT];
      end
    end
  end

  // search bookkeeping for directory tapes
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      fm_passed_q <= 1'b0;
      mark_skipped_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (state_q == ST_MOVE) begin
      if (item_pulse && item_is_fm) begin
        fm_passed_q <= 1'b1;
        fast_q <= 1'b0;
      end else if (end_of_data_mark && mark_skip) begin
        mark_skipped_q <= 1'b1;
        fast_q <= 1'b1;
      end
      if (fin) begin
        fast_q <= 1'b0;
      end
    end
  end

  // flush watchdog; a flush that overruns is taken as failed
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != ST_FLUSH) begin
      flush_cnt_q <= 27'h0000000;
    end else begin
      flush_cnt_q <= 27'(flush_cnt_q + 27'h0000001);
    end
  end

  // ==========================================================
  // second command word merged at full width, then cut to its 16 bits
  wire [31:0] cdb1_merged = merge32({16'h0000, cdb1_q}, wr_data, wr_strb);
  // software registers; command block frozen while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cdb0_q <= 32'h00000000;
      cdb1_q <= 16'h0000;
      dirsup_q <= 1'b0;
      native_q <= 1'b0;
      disc_q <= 1'b0;
    end else begin
      if (wr_cdb0 && !busy) cdb0_q <= merge32(cdb0_q, wr_data, wr_strb);
      if (wr_cdb1 && !busy) cdb1_q <= cdb1_merged[15:0];
      if (wr_ctrl) begin
        dirsup_q <= wr_data[CTRL_DIRSUP];
        native_q <= wr_data[CTRL_NATIVE];
        disc_q <= wr_data[CTRL_DISC];
      end
    end
  end

  // pending-write flag: software sets, a good flush clears, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      after_wr_q <= 1'b0;
    end else if (wr_ctrl) begin
      after_wr_q <= wr_data[CTRL_AFTER_WR];
    end else if (state_q == ST_FLUSH && flush_done && !fin) begin
      after_wr_q <= 1'b0;
    end
  end

  // completion status and sense; a new finish beats a done clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      check_q <= 1'b0;
      key_q <= SK_NONE;
      valid_q <= 1'b0;
      fm_q <= 1'b0;
      end_of_medium_flag_q <= 1'b0;
      physical_tape_end_q <= 1'b0;
      logical_tape_start_q <= 1'b0;
      info_q <= 24'h000000;
      park_q <= 1'b0;
    end else begin
      park_q <= fin && f_park;
      if (fin) begin
        done_q <= 1'b1;
        check_q <= f_check;
        key_q <= f_key;
        valid_q <= f_valid;
        fm_q <= f_fm;
        end_of_medium_flag_q <= f_medium_end;
        physical_tape_end_q <= f_tape_end;
        logical_tape_start_q <= f_tape_start;
        info_q <= f_info;
      end else if (wr_stat && wr_data[SB_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // block type last seen on tape
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fixed_q <= 1'b0;
    end else if (state_q == ST_MOVE && item_pulse && !item_is_fm) begin
      fixed_q <= item_fixed;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rev_after_write;
    state_q == ST_DECODE && !illegal && !zero_noop && need_flush;
  endsequence
  sequence s_flush_then_move;
    flush_req && !move_req ##1 (flush_req || move_req || state_q == ST_IDLE);
  endsequence
  AST_BAD_OPCODE: assert property (state_q == ST_DECODE && opc_w != OPC_SPACE
    |=> done_q && check_q && key_q == SK_ILLEGAL && !move_req)
    else $error("wrong opcode not refused");
  AST_BAD_CODE: assert property (state_q == ST_DECODE && !code_ok
    |=> key_q == SK_ILLEGAL && state_q == ST_IDLE)
    else $error("unsupported code not refused");
  AST_ZERO_COUNT: assert property (state_q == ST_DECODE && !illegal && zero_noop
    |=> done_q && !check_q && !move_req)
    else $error("zero count did not finish cleanly");
  AST_FLUSH_FIRST: assert property (s_rev_after_write |=> s_flush_then_move)
    else $error("reverse space moved before flush");
  AST_FLUSH_FAIL: assert property (flush_req && flush_fail
    |=> check_q && done_q && !move_req [*2])
    else $error("failed flush still spaced");
  AST_FM_STOP: assert property (move_req && fm_stop && !hw_fault && !media_fault
    && !physical_tape_end && !physical_tape_start && !end_of_data_mark
    |=> fm_q && valid_q && key_q == SK_NONE && info_q == $past(residue))
    else $error("filemark stop sense wrong");
  AST_BLANK: assert property (move_req && end_of_data_mark && !mark_skip
    && code_q != CODE_TO_END && !hw_fault && !media_fault && !physical_tape_end
    && !physical_tape_start
    |=> key_q == SK_BLANK && valid_q && check_q)
    else $error("blank tape sense wrong");
  AST_TAPE_END: assert property (move_req && physical_tape_end && !hw_fault
    && !media_fault |=> key_q == SK_MEDIUM && end_of_medium_flag_q && physical_tape_end_q
    && valid_q)
    else $error("physical end sense wrong");
  AST_TAPE_START: assert property (move_req && physical_tape_start
    && !physical_tape_end && !hw_fault && !media_fault |=> park_at_start
    && logical_tape_start_q && end_of_medium_flag_q && key_q == SK_NONE ##1 !park_at_start)
    else $error("physical start handling wrong");
  AST_HW_FAULT: assert property (move_req && hw_fault |=> key_q == SK_HW && check_q)
    else $error("hardware fault key wrong");
  AST_OLD_FORMAT: assert property (state_q == ST_DECODE && code_q == CODE_TO_END
    && !native_q |=> key_q == SK_ILLEGAL && !move_req)
    else $error("end-of-data on old format not refused");
  AST_DISCONNECT: assert property (disc_q && $rose(move_req) |-> bus_release)
    else $error("bus not released while spacing");
endmodule

// file: tape_model.sv
`timescale 1ns/10ps
// far side: one item every other cycle, one chosen event at item number at
module tape_model (
  input wire logic aclk,
  input wire logic move_req,
  input wire logic flush_req,
  input wire logic [2:0] move_kind,
  input wire logic [2:0] ev,
  input wire logic [3:0] at,
  input wire logic ffail,
  output logic item_pulse,
  output logic item_is_fm,
  output logic end_of_data_mark,
  output logic physical_tape_end,
  output logic physical_tape_start,
  output logic media_fault,
  output logic hw_fault,
  output logic flush_done,
  output logic flush_fail
);
  logic [3:0] n_q;
  logic gap_q;
  logic [4:0] hit_q;
  logic go;
  logic here;
  assign go = move_req && !gap_q;
  assign here = go && n_q == at;
  assign {hw_fault, media_fault, physical_tape_start, physical_tape_end, end_of_data_mark} = hit_q;
  // the gap cycle keeps an item from landing after the engine stops
  always @(posedge aclk) begin
    gap_q <= go;
    n_q <= move_req ? n_q + 4'(go) : 4'h0;
    item_pulse <= go && !(here && ev > 3'h1);
    item_is_fm <= go && (move_kind == 3'h1 || (here && ev == 3'h1));
    hit_q <= (here && ev > 3'h1) ? 5'(1 << (ev - 3'h2)) : 5'h0;
    flush_done <= flush_req && !flush_done && !ffail;
    flush_fail <= flush_req && !flush_fail && ffail;
  end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
// commands go in over the register port; status and residue are compared
module testbench;
  import space_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ffail = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, at = 4'h0;
  logic [2:0] ev = 3'h0, move_kind, kd = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flush_req;
  logic move_req, move_reverse, move_fast, park_at_start, bus_release, item_pulse, item_is_fm;
  logic end_of_data_mark, physical_tape_end, physical_tape_start, media_fault, hw_fault;
  logic flush_done, flush_fail;
  logic item_fixed = 1'h0, mv = 1'h0, rv = 1'h0, br = 1'h0, fs = 1'h0, pk = 1'h0;
  logic [23:0] unreadable_blocks = 24'h0;
  logic [31:0] rj [4] = '{32'h0311, 32'h0011, 32'h0211, 32'h0012};
  localparam logic [31:0] SKIP = 32'h0BAD_0BAD;
  int error_cnt = 0, n_tests = 0;
  // short flush limit; the failed-flush case ends on flush_fail, well before it
  space_engine #(.FLUSH_LIMIT(20)) DUT (.*);
  tape_model far_end (.*);
  always #50 aclk = ~aclk;
  // remember any motion, its direction and kind, and the side outputs
  always @(posedge aclk) begin
    if (move_req) begin
      mv <= 1'h1;
      rv <= move_reverse;
      br <= bus_release;
      kd <= move_kind;
    end
    if (move_fast) fs <= 1'h1;
    if (park_at_start) pk <= 1'h1;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // both write halves offered at once, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask
  // load block, start, poll done, compare, clear done
  task automatic run(input logic [31:0] c0, c1, ctl, input logic [2:0] e,
                     input logic [3:0] i, input logic [31:0] st, inf,
                     input logic [31:0] msk = 32'h3FFF);
    ev <= e;
    at <= i;
    mv <= 1'h0;
    fs <= 1'h0;
    pk <= 1'h0;
    wr(REG_CDB0, c0);
    wr(REG_CDB1, c1);
    wr(REG_CTRL, ctl | 32'h1);
    d = 32'h0;
    for (int k = 0; k < 60 && d[SB_DONE] !== 1'h1; k++) rd(REG_STAT);
    chk("status", st, d & msk);
    rd(REG_INFO);
    if (inf != SKIP) chk("info", inf, d);
    wr(REG_STAT, 32'h2);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h20);
    chk("unmapped", 32'h0, d);
    run(32'h11, 32'h0, 32'h0, 3'h0, 4'h0, 32'h2, 32'h0);
    chk("moved", 1'h0, mv);
    item_fixed <= 1'h1;
    run(32'h11, 32'h3, 32'h10, 3'h0, 4'h0, 32'h2002, 32'h0);
    chk("reverse", 1'h0, rv);
    chk("release", 1'h1, br);
    item_fixed <= 1'h0;
    run(32'h11, 32'h5, 32'h0, 3'h1, 4'h2, 32'h306, 32'h3);
    run(32'hFFFF0011, 32'hFD, 32'h8, 3'h4, 4'h1, 32'h1506, 32'hFFFFFFFE);
    chk("reverse", 1'h1, rv);
    chk("park", 1'h1, pk);
    ffail <= 1'h1;
    run(32'hFFFF0011, 32'hFD, 32'h8, 3'h0, 4'h0, 32'h36, SKIP);
    chk("moved", 1'h0, mv);
    ffail <= 1'h0;
    run(32'h0111, 32'h4, 32'h0, 3'h2, 4'h2, 32'h186, 32'h2);
    run(32'h0311, 32'h1, 32'h4, 3'h2, 4'h3, 32'h2, 32'h0);
    chk("kind", 32'h3, kd);
    foreach (rj[k]) run(rj[k], 32'h2, {28'h0, k == 1, 3'h0}, 3'h0, 4'h0, 32'h56, SKIP);
    run(32'h11, 32'h6, 32'h0, 3'h3, 4'h1, 32'hD36, 32'h5);
    run(32'h11, 32'h4, 32'h0, 3'h6, 4'h0, 32'h46, SKIP, 32'hFF);
    run(32'h11, 32'h4, 32'h0, 3'h5, 4'h2, 32'h36, 32'h2, 32'hFF);
    unreadable_blocks <= 24'h000005;
    run(32'hFFFF0011, 32'hFC, 32'h0, 3'h5, 4'h1, 32'h36, 32'hFFFFFFFB, 32'hFF);
    run(32'h0111, 32'h2, 32'h2, 3'h2, 4'h0, 32'h2, 32'h0);
    chk("fast", 1'h1, fs);
    run(32'h0111, 32'h8002, 32'h2, 3'h2, 4'h0, 32'h186, 32'h2);
    chk("fast", 1'h0, fs);
    run(32'h0111, 32'h2, 32'h0, 3'h2, 4'h0, 32'h186, 32'h2);
    wrap_up();
  end
  // hang guard, far beyond the whole command list
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
endmodule
